// ### lbac_pkg.sv
// package of shared constants and carrier types for the lpddr2 burst access controller
package lbac_pkg;

    // user command opcodes
    typedef enum logic [2:0] {
        OP_NOP   = 3'h0,
        OP_READ  = 3'h1,
        OP_WRITE = 3'h2,
        OP_TERM  = 3'h3,
        OP_ACT   = 3'h4,
        OP_PRE   = 3'h5
    } lbac_op_t;

    // burst length as held in the device mode register
    typedef enum logic [1:0] {
        BLEN4  = 2'h0,
        BLEN8  = 2'h1,
        BLEN16 = 2'h2
    } lbac_blen_t;

    // rising-half command codes, low ca bits
    localparam logic [2:0] CA_READ  = 3'h5;   // ca0=1 ca1=0 ca2=1
    localparam logic [2:0] CA_WRITE = 3'h1;   // ca0=1 ca1=0 ca2=0
    localparam logic [3:0] CA_TERM  = 4'h3;   // ca0=1 ca1=1 ca2=0 ca3=0
    localparam logic [3:0] CA_PRE   = 4'hb;   // ca0=1 ca1=1 ca2=0 ca3=1
    localparam logic [1:0] CA_ACT   = 2'h2;   // ca0=0 ca1=1

    // field positions on the ca bus
    localparam int COL_RISE_LSB = 5;          // column bits on ca5r..ca6r
    localparam int COL_FALL_LSB = 1;          // column bits on ca1f..ca9f
    localparam int AP_FALL_BIT  = 0;          // auto-precharge on ca0f
    localparam int BANK_LSB     = 7;          // bank on ca7r..ca9r
    localparam int ROW_RISE_LSB = 2;          // low row bits on ca2r..ca6r

    // timing figures
    localparam int         SYS_PS  = 5000;    // system clock period in ps
    localparam logic [5:0] TCCD_CK = 6'h02;   // least column-to-column gap
    localparam int         WL_MAX  = 4;       // largest write latency
    localparam logic [5:0] CNT_MAX = 6'h3f;   // clock counters saturate here

    // user command carrier
    typedef struct packed {
        lbac_op_t    op;
        logic [2:0]  bank;
        logic [14:0] addr;   // row for activate, column in low 11 bits
        logic        ap;     // auto-precharge for read and write
    } lbac_cmd_t;

    // write launch slot travelling down the latency line
    typedef struct packed {
        logic       start;
        logic       stop;
        logic [4:0] beats;
    } lbac_wslot_t;

    // time to whole clock cycles, rounded up, never below one
    function automatic int lbac_ru(input int t, input int p);
        int r;
        r = (t + p - 1) / p;
        return (r < 1) ? 1 : r;
    endfunction : lbac_ru

endpackage : lbac_pkg

// ### lbac_host.sv
// host-side burst controller driving the lpddr2 command, address and data pins
`timescale 1ns/1ps
module lbac_host
    import lbac_pkg::*;
#(
    parameter int DQ_W          = 16,      // data width
    parameter int HALF_DIV      = 13,      // system clocks per half link clock
    parameter int TDQSCK_MAX_PS = 5500,    // largest read strobe skew
    parameter int TWTR_PS       = 7500,    // write to read turnaround
    parameter int TWR_PS        = 15000,   // write recovery
    parameter int TRCD_PS       = 18000    // activate to access
) (
    // clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  srst,
    // user command port
    input  wire logic                  cmdValid,
    input  wire lbac_cmd_t             cmd,
    output logic                       cmdReady,
    // mode settings, must match the device mode registers
    input  wire lbac_blen_t            cfgBlen,
    input  wire logic [3:0]            cfgRl,
    input  wire logic [2:0]            cfgWl,
    // write data stream
    input  wire logic [DQ_W-1:0]       wrData,
    input  wire logic [DQ_W/8-1:0]     wrMask,
    output logic                       wrTake,
    // read data stream
    output logic [DQ_W-1:0]            rdData,
    output logic                       rdValid,
    // link pins
    output logic                       ck,
    output logic                       ckN,
    output logic                       csN,
    output logic [9:0]                 ca,
    output logic [DQ_W-1:0]            dqOut,
    output logic                       dqOe,
    input  wire logic [DQ_W-1:0]       dqIn,
    output logic [DQ_W/8-1:0]          dmOut,
    output logic                       dmOe,
    output logic                       dqsOut,
    output logic                       dqsOe,
    input  wire logic                  dqsIn
);

    localparam int         DM_W     = DQ_W / 8;
    localparam int         WPIPE    = 2 * WL_MAX;          // half clocks of write latency
    localparam int         CK_PS    = 2 * HALF_DIV * SYS_PS;
    localparam logic [5:0] DQSCK_CK = 6'(lbac_ru(TDQSCK_MAX_PS, CK_PS));
    localparam logic [5:0] TWTR_CK  = 6'(lbac_ru(TWTR_PS, CK_PS));
    localparam logic [5:0] TWR_CK   = 6'(lbac_ru(TWR_PS, CK_PS));
    localparam logic [5:0] TRCD_CK  = 6'(lbac_ru(TRCD_PS, CK_PS));
    localparam logic [7:0] DIV_LAST = 8'(HALF_DIV - 1);

    // whole state of the controller
    typedef struct packed {
        logic [7:0]                  div;       // half clock divider
        logic                        ck;        // link clock level
        logic                        csN;       // chip select pin
        logic [9:0]                  ca;        // ca pins
        logic [9:0]                  caFall;    // falling half waiting
        logic                        pValid;    // command waits for rise
        lbac_cmd_t                   pCmd;      // that command
        logic [5:0]                  sinceCmd;  // clocks since read/write
        logic [5:0]                  sinceAct;  // clocks since activate
        logic                        lastValid; // a read/write was issued
        logic                        lastWr;    // it was a write
        logic                        lastAp;    // with auto-precharge
        logic                        bstDone;   // it was already terminated
        logic [4:0]                  effBl;     // its effective length
        lbac_wslot_t [WPIPE-1:0]     wpipe;     // write latency line
        logic [4:0]                  wLeft;     // write beats still due
        logic [DQ_W-1:0]             dq;        // write data pins
        logic [DM_W-1:0]             dm;        // mask pins
        logic                        dqs;       // strobe pin
        logic                        dqOe;      // data/mask drive
        logic                        dqsOe;     // strobe drive
        logic [DQ_W-1:0]             dqS1;      // read data sync stage 1
        logic [DQ_W-1:0]             dqS2;      // read data sync stage 2
        logic                        dqsS1;     // strobe sync stage 1
        logic                        dqsS2;     // strobe sync stage 2
        logic                        dqsS3;     // edge detect
        logic                        dqsS4;     // sample delay
        logic [6:0]                  rdLeft;    // read beats expected
        logic [DQ_W-1:0]             rdData;    // captured read word
        logic                        rdValid;   // capture pulse
    } lbac_state_t;

    lbac_state_t s;
    lbac_state_t next_s;

    // burst length in beats
    function automatic logic [4:0] bl_beats(input lbac_blen_t b);
        case (b)
            BLEN4:   bl_beats = 5'h04;
            BLEN8:   bl_beats = 5'h08;
            BLEN16:  bl_beats = 5'h10;
            default: bl_beats = 5'h04;
        endcase
    endfunction : bl_beats

    // counter step that saturates instead of wrapping
    function automatic logic [5:0] sat_inc(input logic [5:0] v);
        sat_inc = (v == CNT_MAX) ? v : v + 6'h01;
    endfunction : sat_inc

    // next-state logic
    always_comb begin
        logic        tick;
        logic [5:0]  gap;
        logic [5:0]  lastHalf;
        logic [5:0]  rlw;
        logic [5:0]  wlw;
        logic        over;
        logic        intr;
        logic        legal;
        logic [4:0]  bl;
        logic [4:0]  cut;
        logic [4:0]  beatsNow;
        logic [3:0]  wIdx;
        lbac_wslot_t head;
        tick     = (s.div == DIV_LAST);
        bl       = bl_beats(cfgBlen);
        gap      = sat_inc(s.sinceCmd);
        lastHalf = {2'h0, s.effBl[4:1]};
        rlw      = {2'h0, cfgRl};
        wlw      = {3'h0, cfgWl};
        over     = !s.lastValid || (gap >= lastHalf);
        // interrupt only for bl8/16, on even gaps that meet tccd
        intr     = (cfgBlen != BLEN4) && !gap[0] && (gap >= TCCD_CK);
        wIdx     = {cfgWl, 1'b0} - 4'h1;
        cut      = {gap[3:0], 1'b0};
        head     = s.wpipe[0];
        beatsNow = s.wLeft;
        legal    = 1'b0;
        cmdReady = 1'b0;
        wrTake   = 1'b0;
        next_s   = s;

        next_s.div = tick ? 8'h00 : s.div + 8'h01;

        // two-flop synchronisers on the device-driven pins
        next_s.dqS1  = dqIn;
        next_s.dqS2  = s.dqS1;
        next_s.dqsS1 = dqsIn;
        next_s.dqsS2 = s.dqsS1;
        next_s.dqsS3 = s.dqsS2;
        next_s.dqsS4 = s.dqsS3;

        // each strobe edge is one beat; sampling one clock late lands mid-beat,
        // so the link clock must stay several system clocks per half period
        next_s.rdValid = 1'b0;
        if ((s.dqsS3 != s.dqsS4) && (s.rdLeft != 7'h00)) begin
            next_s.rdData  = s.dqS2;
            next_s.rdValid = 1'b1;
            next_s.rdLeft  = s.rdLeft - 7'h01;
        end

        // legality of the offered command at the coming rising edge
        case (cmd.op)
            OP_READ: begin
                if (!s.lastValid || s.bstDone)
                    legal = 1'b1;
                else if (s.lastWr)
                    legal = gap >= wlw + 6'h01 + lastHalf + TWTR_CK;
                else
                    legal = over || intr;
                legal = legal && (sat_inc(s.sinceAct) >= TRCD_CK);
                if (s.lastValid && s.lastWr && s.bstDone)
                    legal = legal && (gap >= wlw + 6'h01 + lastHalf + TWTR_CK);
            end
            OP_WRITE: begin
                if (!s.lastValid)
                    legal = 1'b1;
                else if (!s.lastWr)
                    legal = gap + wlw >= rlw + DQSCK_CK + lastHalf + 6'h01;
                else
                    legal = over || (intr && !s.lastAp && !s.bstDone);
                legal = legal && (sat_inc(s.sinceAct) >= TRCD_CK);
            end
            OP_TERM: begin
                // only on a live burst, on an even gap, once per burst
                legal = s.lastValid && !s.bstDone && !gap[0]
                        && (gap <= lastHalf - 6'h01);
            end
            OP_PRE: begin
                if (s.lastValid && s.lastWr)
                    legal = gap >= wlw + lastHalf + 6'h01 + TWR_CK;
                else
                    legal = over;
            end
            OP_ACT:  legal = over;
            default: legal = 1'b0;
        endcase

        if (tick) begin
            next_s.ck = !s.ck;

            // write latency line advances one slot per half clock
            for (int i = 0; i < WPIPE - 1; i++) begin
                next_s.wpipe[i] = s.wpipe[i+1];
            end
            next_s.wpipe[WPIPE-1] = '0;

            if (!s.ck) begin
                // rising edge: the waiting command is taken by the device now
                next_s.sinceCmd = gap;
                next_s.sinceAct = sat_inc(s.sinceAct);
                next_s.ca       = s.caFall;
                next_s.pValid   = 1'b0;
                if (s.pValid) begin
                    case (s.pCmd.op)
                        OP_READ, OP_WRITE: begin
                            // a cut burst keeps only twice the gap
                            if (s.lastValid && !s.bstDone && !over && !s.lastWr)
                                next_s.rdLeft = next_s.rdLeft - (s.effBl - cut);
                            next_s.lastValid = 1'b1;
                            next_s.lastWr    = (s.pCmd.op == OP_WRITE);
                            next_s.lastAp    = s.pCmd.ap;
                            next_s.bstDone   = 1'b0;
                            next_s.effBl     = bl;
                            next_s.sinceCmd  = 6'h00;
                            if (s.pCmd.op == OP_READ)
                                next_s.rdLeft = next_s.rdLeft + {2'h0, bl};
                            else
                                next_s.wpipe[wIdx[2:0]] = '{start: 1'b1, stop: 1'b0, beats: bl};
                        end
                        OP_TERM: begin
                            // acts on the latest burst only
                            if (s.lastWr)
                                next_s.wpipe[wIdx[2:0]] = '{start: 1'b0, stop: 1'b1, beats: 5'h00};
                            else
                                next_s.rdLeft = next_s.rdLeft - (s.effBl - cut);
                            next_s.effBl   = cut;
                            next_s.bstDone = 1'b1;
                        end
                        OP_ACT:  next_s.sinceAct = 6'h00;
                        default: next_s.sinceAct = next_s.sinceAct;
                    endcase
                end
            end else begin
                // falling edge: place the next command's rising half, or idle
                next_s.csN = 1'b1;
                next_s.ca  = 10'h000;
                if (cmdValid && legal) begin
                    cmdReady      = 1'b1;
                    next_s.pValid = 1'b1;
                    next_s.pCmd   = cmd;
                    next_s.csN    = 1'b0;
                    case (cmd.op)
                        OP_READ, OP_WRITE: begin
                            next_s.ca[2:0] = (cmd.op == OP_READ) ? CA_READ : CA_WRITE;
                            next_s.ca[COL_RISE_LSB +: 2] = cmd.addr[1:0];
                            next_s.ca[BANK_LSB +: 3]     = cmd.bank;
                            next_s.caFall = {cmd.addr[10:2], cmd.ap};
                        end
                        OP_TERM: begin
                            next_s.ca[3:0] = CA_TERM;
                            next_s.caFall  = 10'h000;
                        end
                        OP_PRE: begin
                            next_s.ca[3:0]           = CA_PRE;
                            next_s.ca[BANK_LSB +: 3] = cmd.bank;
                            next_s.caFall            = 10'h000;
                        end
                        OP_ACT: begin
                            next_s.ca[1:0]               = CA_ACT;
                            next_s.ca[ROW_RISE_LSB +: 5] = cmd.addr[4:0];
                            next_s.ca[BANK_LSB +: 3]     = cmd.bank;
                            next_s.caFall                = cmd.addr[14:5];
                        end
                        default: next_s.csN = 1'b1;
                    endcase
                end
            end

            // a slot at the head starts or stops the write beats
            if (head.start)
                beatsNow = head.beats;
            else if (head.stop)
                beatsNow = 5'h00;

            if (beatsNow != 5'h00) begin
                // one beat per half clock, strobe toggling with it
                wrTake       = 1'b1;
                next_s.dq    = wrData;
                next_s.dm    = wrMask;
                next_s.dqs   = !s.dqs;
                next_s.dqOe  = 1'b1;
                next_s.dqsOe = 1'b1;
                next_s.wLeft = beatsNow - 5'h01;
            end else if (s.wpipe[1].start) begin
                // strobe held low for a half clock before the first beat
                next_s.dqs   = 1'b0;
                next_s.dqOe  = 1'b0;
                next_s.dqsOe = 1'b1;
                next_s.wLeft = 5'h00;
            end else begin
                next_s.dqs   = 1'b0;
                next_s.dqOe  = 1'b0;
                next_s.dqsOe = 1'b0;
                next_s.wLeft = 5'h00;
            end
        end
    end

    // state register, synchronous reset
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            s          <= '0;
            s.csN      <= 1'b1;
            s.sinceCmd <= CNT_MAX;
            s.sinceAct <= CNT_MAX;
        end else begin
            s <= next_s;
        end
    end

    // pins and streams straight from the state
    assign ck     = s.ck;
    assign ckN    = !s.ck;
    assign csN    = s.csN;
    assign ca     = s.ca;
    assign dqOut  = s.dq;
    assign dqOe   = s.dqOe;
    assign dmOut  = s.dm;
    assign dmOe   = s.dqOe;
    assign dqsOut = s.dqs;
    assign dqsOe  = s.dqsOe;
    assign rdData = s.rdData;
    assign rdValid = s.rdValid;

endmodule : lbac_host

// ### lbac_host_properties.sv
// concurrent checks on the ports of the burst controller
`timescale 1ns/1ps
module lbac_host_chk
    import lbac_pkg::*;
#(
    parameter int DQ_W     = 16,  // data width
    parameter int HALF_DIV = 13   // system clocks per half link clock
) (
    // clock and reset
    input wire logic              sys_clk,
    input wire logic              srst,
    // command port
    input wire logic              cmdValid,
    input wire lbac_cmd_t         cmd,
    input wire logic              cmdReady,
    // data streams
    input wire logic [DQ_W-1:0]   wrData,
    input wire logic [DQ_W/8-1:0] wrMask,
    input wire logic              wrTake,
    input wire logic              rdValid,
    // link pins
    input wire logic              ck,
    input wire logic              csN,
    input wire logic [9:0]        ca,
    input wire logic [DQ_W-1:0]   dqOut,
    input wire logic              dqOe,
    input wire logic [DQ_W/8-1:0] dmOut,
    input wire logic              dqsOut,
    input wire logic              dqsOe,
    input wire logic              dqsIn
);
    localparam int FALL_DLY = HALF_DIV + 1;  // take to falling half on ca
    logic [9:0] colHold;                     // fall half of the last command
    wire        isCol = cmd.op == OP_READ || cmd.op == OP_WRITE;
    // remember the fall half, the next command is a whole ck away
    always_ff @(posedge sys_clk) begin
        if (cmdReady) begin
            colHold <= {cmd.addr[10:2], cmd.ap};
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    a_reset_idle: assert property (disable iff (1'b0)
        srst |=> csN && ca == 10'h000 && !dqOe && !dqsOe && !rdValid && !ck)
        else $error("link not idle after reset");
    a_take_legal: assert property (cmdReady |-> cmdValid && ck && cmd.op != OP_NOP)
        else $error("command taken off a decision point");
    a_read_code: assert property (cmdReady && cmd.op == OP_READ |=>
        !csN && ca[2:0] == CA_READ && ca[6:5] == $past(cmd.addr[1:0]))
        else $error("read code or column wrong");
    a_write_code: assert property (cmdReady && cmd.op == OP_WRITE |=>
        !csN && ca[2:0] == CA_WRITE && ca[6:5] == $past(cmd.addr[1:0]))
        else $error("write code or column wrong");
    a_term_code: assert property (cmdReady && cmd.op == OP_TERM |=>
        !csN && ca[3:0] == CA_TERM)
        else $error("terminate code wrong");
    a_col_fall: assert property (cmdReady && isCol |-> ##FALL_DLY ca == colHold)
        else $error("falling column half wrong");
    a_cs_period: assert property ($fell(csN) |-> ##HALF_DIV ($rose(ck) && !csN))
        else $error("select not held to the command edge");
    a_ck_half: assert property ($rose(ck) |-> ##HALF_DIV $fell(ck))
        else $error("link clock half period wrong");
    a_wr_preamble: assert property ($rose(dqsOe) |->
        !dqsOut && !dqOe ##HALF_DIV (dqOe && dqsOut))
        else $error("write preamble wrong");
    a_wr_beat: assert property (wrTake |=>
        dqOe && dqOut == $past(wrData) && dmOut == $past(wrMask))
        else $error("write beat not on the pins");
    a_oe_pair: assert property (dqOe |-> dqsOe)
        else $error("data driven without strobe");
    a_rd_edge: assert property (rdValid |-> $past(dqsIn, 4) != $past(dqsIn, 5))
        else $error("read beat without strobe edge");
    c_read: cover property (cmdReady && cmd.op == OP_READ);
    c_write: cover property (cmdReady && cmd.op == OP_WRITE);
    c_term: cover property (cmdReady && cmd.op == OP_TERM);
    c_beat: cover property (rdValid);
endmodule : lbac_host_chk

// ### lbac_dev_model.sv
// behavioural lpddr2 device answering read and write bursts
`timescale 1ns/1ps
module lbac_dev_model #(
    parameter int RL = 3,  // read latency in ck
    parameter int WL = 1,  // write latency in ck
    parameter int BL = 8   // beats per burst
) (
    // link from the host, dq and dqs as wire levels
    input  wire logic        ck,
    input  wire logic        csN,
    input  wire logic [9:0]  ca,
    input  wire logic [15:0] dq,
    input  wire logic [1:0]  dm,
    input  wire logic        dqs,
    input  wire logic        dqsOe,
    // read drive
    output logic [15:0]      devDq,
    output logic             devDqs
);
    logic [15:0] mem [64];  // array with a preset pattern
    logic [7:0]  rs [64];   // read slot per half clock: valid, even, column
    logic [6:0]  ws [64];   // write slot per half clock: valid, column
    logic [9:0]  rise;      // rising command half
    // the host moves ca on the very ck edge that samples it, so read the held value
    wire  [9:0]  #1 caD = ca;
    logic [5:0]  col;
    int          hc = 0;
    int          hcCmd = 0;
    bit          pend = 0;
    initial begin
        devDq = 16'h0000;
        devDqs = 1'b0;
        for (int i = 0; i < 64; i++) begin
            mem[i] = 16'ha500 + 16'(i);
            rs[i] = 8'h00;
            ws[i] = 7'h00;
        end
    end
    // each ck edge: decode commands, then drive this half's read beat
    always @(posedge ck or negedge ck) begin
        hc = hc + 1;
        if (ck && !csN) begin
            rise = caD;
            hcCmd = hc;
            pend = 1;
        end else if (!ck && pend) begin
            pend = 0;
            col = {caD[4:1], rise[6:5]};
            for (int k = 0; k < 16; k++) begin
                // a later read overwrites the tail, which truncates it
                if (rise[2:0] == 3'h5 && k < BL)
                    rs[(hcCmd + 2*RL + k) % 64] = {1'b1, ~k[0], 6'(col + k)};
                if (rise[2:0] == 3'h1 && k < BL)
                    ws[(hcCmd + 2*WL + k) % 64] = {1'b1, 6'(col + k)};
                if (rise[3:0] == 4'h3)
                    rs[(hcCmd + 2*RL + k) % 64][7] = 1'b0;
            end
        end
        // strobe low between bursts doubles as the preamble
        devDqs = rs[hc % 64][7] & rs[hc % 64][6];
        devDq = rs[hc % 64][7] ? mem[rs[hc % 64][5:0]] : ~devDq;
        rs[hc % 64] = 8'h00;
        ws[(hc + 32) % 64] = 7'h00;
    end
    // host beats change with the strobe, so sample a quarter ck later
    always @(posedge dqs or negedge dqs) begin
        if (dqsOe === 1'b1) begin
            #10;
            if (ws[hc % 64][6]) begin
                if (!dm[0]) mem[ws[hc % 64][5:0]][7:0] = dq[7:0];
                if (!dm[1]) mem[ws[hc % 64][5:0]][15:8] = dq[15:8];
            end
        end
    end
endmodule : lbac_dev_model

// ### tb_top.sv
// self-checking bench for the lpddr2 burst controller
`timescale 1ns/1ps
module tb_top;
    import lbac_pkg::*;
    localparam int HD = 4;  // short link clock keeps the run brief
    typedef struct packed {logic [5:0] col; logic mEn;} lbac_row_t;
    lbac_row_t   rows [3] = '{'{6'h00, 1'b0}, '{6'h08, 1'b1}, '{6'h18, 1'b1}};
    logic        sys_clk = 1'b0;
    logic        srst = 1'b1;
    logic        cmdValid = 1'b0;
    lbac_cmd_t   cmd = '0;
    logic        mEn = 1'b0;     // byte masking of write beats
    logic [7:0]  wIdx = 8'h00;   // write beat count, also the data
    logic [15:0] wrData, dqIn, devDq, rdData, dqOut;
    logic [1:0]  wrMask, dmOut;
    logic        cmdReady, wrTake, rdValid, ck, ckN, csN, dqOe, dmOe;
    logic        dqsOut, dqsOe, dqsIn, devDqs;
    logic [9:0]  ca;
    logic [15:0] rBuf [256];
    logic [15:0] expMem [64];
    int          rCnt = 0, mismatches = 0, compares = 0, b, w0;
    initial forever #2.5 sys_clk = ~sys_clk;
    // wire levels from the host's enables, the device driving otherwise
    assign dqIn = dqOe ? dqOut : devDq;
    assign dqsIn = dqsOe ? dqsOut : devDqs;
    always_comb wrData = {8'hc0, wIdx};
    always_comb wrMask = mEn ? wIdx[1:0] : 2'h0;
    // count write beats, collect read beats
    always @(posedge sys_clk) begin
        if (wrTake === 1'b1) wIdx <= wIdx + 8'h01;
        if (rdValid === 1'b1) begin
            rBuf[rCnt % 256] <= rdData;
            rCnt <= rCnt + 1;
        end
    end
    lbac_host #(.HALF_DIV(HD)) lbac_host_i (.sys_clk, .srst, .cmdValid, .cmd, .cmdReady,
        .cfgBlen(BLEN8), .cfgRl(4'h3), .cfgWl(3'h1), .wrData, .wrMask, .wrTake, .rdData,
        .rdValid, .ck, .ckN, .csN, .ca, .dqOut, .dqOe, .dqIn, .dmOut, .dmOe, .dqsOut,
        .dqsOe, .dqsIn);
    lbac_dev_model #(.RL(3), .WL(1), .BL(8)) lbac_dev_model_i (.ck, .csN, .ca, .dq(dqIn),
        .dm(dmOut), .dqs(dqsIn), .dqsOe, .devDq, .devDqs);
    task automatic close_out();
        if (mismatches == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : close_out
    task automatic chk(input bit ok, input string msg);
        compares++;
        if (!ok) begin
            mismatches++;
            $display("Error at %0t: %s", $time, msg);
        end
    endtask : chk
    // offer a command; hold keeps valid up for a back-to-back follower
    task automatic issue(input lbac_op_t op, input logic [5:0] col, input bit hold, ex);
        bit took;
        took = 0;
        cmd <= '{op: op, bank: 3'h1, addr: 15'(col), ap: 1'b0};
        cmdValid <= 1'b1;
        for (int i = 0; i < (ex ? 400 : 40) && !took; i++) begin
            @(posedge sys_clk);
            took = (cmdReady === 1'b1);
        end
        if (!hold || !took) begin
            cmdValid <= 1'b0;
            @(posedge sys_clk);  // an edge between two offers
        end
        chk(took == ex, "command acceptance");
        if (ex && !took) close_out();
    endtask : issue
    // shadow of the array after a write of n beats
    task automatic expWr(input logic [5:0] col, input int n, input logic me);
        logic [7:0] ix;
        logic [5:0] a;
        for (int k = 0; k < n; k++) begin
            ix = wIdx + 8'(k);
            a = col + 6'(k);
            if (!(me && ix[0])) expMem[a][7:0] = ix;
            if (!(me && ix[1])) expMem[a][15:8] = 8'hc0;
        end
    endtask : expWr
    task automatic waitRd(input int n);
        for (int i = 0; i < 800 && rCnt < n; i++) @(posedge sys_clk);
        repeat (60) @(posedge sys_clk);
        chk(rCnt == n, "read beat count");
        if (rCnt < n) close_out();
    endtask : waitRd
    task automatic rdChk(input int base, input logic [5:0] col, input int n);
        for (int k = 0; k < n; k++)
            chk(rBuf[(base + k) % 256] === expMem[6'(col + k)], "read data");
    endtask : rdChk
    // main sequence
    initial begin
        for (int i = 0; i < 64; i++) expMem[i] = 16'ha500 + 16'(i);
        repeat (6) @(posedge sys_clk);
        chk(csN === 1'b1 && dqOe === 1'b0 && dmOe === 1'b0 && ck === 1'b0 && ckN === 1'b1,
            "link busy in reset");
        srst <= 1'b0;
        @(posedge sys_clk);
        issue(OP_ACT, 6'h00, 0, 1);
        foreach (rows[r]) begin
            mEn <= rows[r].mEn;
            w0 = wIdx;
            expWr(rows[r].col, 8, rows[r].mEn);
            issue(OP_WRITE, rows[r].col, 0, 1);
            b = rCnt;
            issue(OP_READ, rows[r].col, 0, 1);
            waitRd(b + 8);
            rdChk(b, rows[r].col, 8);
            chk(wIdx === 8'(w0 + 8), "write beat count");
        end
        // read cut by a read two clocks later
        b = rCnt;
        issue(OP_READ, 6'h00, 1, 1);
        issue(OP_READ, 6'h08, 0, 1);
        waitRd(b + 12);
        rdChk(b, 6'h00, 4);
        rdChk(b + 4, 6'h08, 8);
        // read cut by terminate, then a stray terminate is refused
        b = rCnt;
        issue(OP_READ, 6'h18, 1, 1);
        issue(OP_TERM, 6'h00, 0, 1);
        waitRd(b + 4);
        rdChk(b, 6'h18, 4);
        issue(OP_TERM, 6'h00, 0, 0);
        // write cut by terminate keeps only four beats
        mEn <= 1'b0;
        w0 = wIdx;
        expWr(6'h28, 4, 1'b0);
        issue(OP_WRITE, 6'h28, 1, 1);
        issue(OP_TERM, 6'h00, 0, 1);
        repeat (100) @(posedge sys_clk);
        chk(wIdx === 8'(w0 + 4), "terminated write beats");
        b = rCnt;
        issue(OP_READ, 6'h28, 0, 1);
        waitRd(b + 8);
        rdChk(b, 6'h28, 8);
        close_out();
    end
endmodule : tb_top
bind lbac_host lbac_host_chk #(.DQ_W(DQ_W), .HALF_DIV(HALF_DIV)) lbac_host_chk_i (.sys_clk,
    .srst, .cmdValid, .cmd, .cmdReady, .wrData, .wrMask, .wrTake, .rdValid, .ck, .csN, .ca,
    .dqOut, .dqOe, .dmOut, .dqsOut, .dqsOe, .dqsIn);
